// ===== src/irqflag_pkg.sv
// constants shared by the interrupt-flag logic of the two-wire master
// assumes a 32-bit avalon slave port with byte addresses
package irqflag_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int EV_W = 6;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_FLAG = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_MASK = 4'hc;
    // control register fields
    localparam int CTRL_MASTER = 0;
    localparam int CTRL_WAIT = 1;
    localparam int CTRL_ACK_CHECK_ENABLE = 2;
    localparam int CTRL_FS = 3;
    localparam int CTRL_FSX = 4;
    localparam int CTRL_START = 5;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
    // flag register fields
    localparam int FLAG_IRQ = 0;
    localparam int FLAG_TXE = 1;
    localparam int FLAG_ACK_RECEIVED_BIT = 2;
    localparam int FLAG_AL = 3;
    localparam int FLAG_W = 4;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 4'h0;
    // event bits of status and mask registers
    localparam int EV_START = 0;
    localparam int EV_WAIT8 = 1;
    localparam int EV_DONE9 = 2;
    localparam int EV_ADDR_AL = 3;
    localparam int EV_NACK = 4;
    localparam int EV_AL = 5;
    localparam logic [EV_W-1:0] EV_RESET = 6'h00;
    // serial clock counting
    localparam int BIT_W = 4;
    localparam logic [BIT_W-1:0] BIT_DATA_LAST = 4'h8;
    localparam logic [BIT_W-1:0] BIT_ZERO = 4'h0;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_START_PEND = 4'b0010,
        ST_XFER = 4'b0100,
        ST_LOST = 4'b1000
    } master_state_t;
endpackage

// ===== src/line_events_if.sv
// line events carried from the pin monitor and frame counter to the flag core
// all signals are on sys_clk
`timescale 1ns/1ps
interface line_events_if;
    import irqflag_pkg::*;
    logic scl_lvl;
    logic sda_lvl;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [BIT_W-1:0] bit_index;
    logic first_frame;
    logic in_frame;
    logic eighth_fall;
    logic ninth_rise;
    modport mon (output scl_lvl, sda_lvl, scl_rise, scl_fall, start_seen, stop_seen);
    modport cnt (input scl_rise, scl_fall, start_seen, stop_seen,
                 output bit_index, first_frame, in_frame, eighth_fall, ninth_rise);
    modport core (input scl_lvl, sda_lvl, scl_rise, scl_fall, start_seen, stop_seen,
                  bit_index, first_frame, in_frame, eighth_fall, ninth_rise);
endinterface // line_events_if

// ===== src/line_monitor.sv
// samples the serial clock and data pins and reports edges, start and stop
// assumes pins asynchronous to sys_clk; two flops before any logic reads them
`timescale 1ns/1ps
module line_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // pins
    input wire logic scl_in,
    input wire logic sda_in,
    // events
    line_events_if.mon ev
);
    import irqflag_pkg::*;
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= 2'h3;
            sync <= 2'h3;
            prev <= 2'h3;
        end else begin
            meta <= {scl_in, sda_in};
            sync <= meta;
            prev <= sync;
        end
    end

    assign ev.scl_lvl = sync[1];
    assign ev.sda_lvl = sync[0];
    assign ev.scl_rise = sync[1] & ~prev[1];
    assign ev.scl_fall = ~sync[1] & prev[1];
    // data moving while the clock stays high marks start or stop
    assign ev.start_seen = sync[1] & prev[1] & prev[0] & ~sync[0];
    assign ev.stop_seen = sync[1] & prev[1] & ~prev[0] & sync[0];
endmodule // line_monitor

// ===== src/frame_counter.sv
// counts serial clock rises inside a frame and flags the 8th fall and 9th rise
// assumes edge pulses from line_monitor on the same clock
`timescale 1ns/1ps
module frame_counter (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // events
    line_events_if.cnt ev
);
    import irqflag_pkg::*;
    logic [BIT_W-1:0] idx;
    logic first;
    logic active;
    wire logic at_last = (idx == BIT_DATA_LAST);
    wire logic byte_end = ev.scl_fall & (idx == BIT_DATA_LAST + 4'h1);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            idx <= BIT_ZERO;
            first <= 1'b0;
            active <= 1'b0;
        end else if (ev.start_seen) begin
            idx <= BIT_ZERO;
            first <= 1'b1;
            active <= 1'b1;
        end else if (ev.stop_seen) begin
            idx <= BIT_ZERO;
            first <= 1'b0;
            active <= 1'b0;
        end else if (active && ev.scl_rise) begin
            idx <= idx + 4'h1;
        end else if (byte_end) begin
            // the low phase after the 9th clock opens the next byte
            idx <= BIT_ZERO;
            first <= 1'b0;
        end
    end

    assign ev.bit_index = idx;
    assign ev.first_frame = first;
    assign ev.in_frame = active;
    assign ev.eighth_fall = active & at_last & ev.scl_fall;
    assign ev.ninth_rise = active & at_last & ev.scl_rise;
endmodule // frame_counter

// ===== src/irq_flag_core.sv
// interrupt request flag logic of a two-wire bus master, with avalon-mm registers
// assumes pins scl_in/sda_in asynchronous; sda_released from the shifter on sys_clk
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
// What this block does
// - flag resets to 0, drives iface_irq_flag; CPU irq comes from masked event status
// - format bits, wait bit, ack enable steer setting
// - master start seen on lines sets flag
// - wait insertion sets flag at 8th fall
// - no wait sets flag at 9th rise
// - address after lost arbitration sets flag
// - nack with checking sets ack bit, flag
// - arbitration lost sets flag
module irq_flag_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // avalon-mm slave
    input wire logic [irqflag_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [irqflag_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [irqflag_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    // from the data shifter
    input wire logic sda_released,
    // toward the cpu
    output logic iface_irq_flag,
    output logic irq
);
    import irqflag_pkg::*;

    line_events_if ev ();

    line_monitor u_mon (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev.mon)
    );

    frame_counter u_cnt (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ev(ev.cnt)
    );

    function automatic logic [DATA_W-1:0] zext_ctrl(input logic [CTRL_W-1:0] v);
        return {{(DATA_W-CTRL_W){1'b0}}, v};
    endfunction

    function automatic logic [DATA_W-1:0] zext_ev(input logic [EV_W-1:0] v);
        return {{(DATA_W-EV_W){1'b0}}, v};
    endfunction

    // software-visible state
    logic [CTRL_W-1:0] ctrl;
    logic [FLAG_W-1:0] flags;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic clear_armed;
    logic bus_ack;
    logic [DATA_W-1:0] rdata;
    master_state_t state;
    master_state_t next_state;

    // bus decode
    wire logic bus_req = avs_read | avs_write;
    wire logic bus_done = bus_req & bus_ack;
    wire logic sel_ctrl = (avs_address == OFS_CTRL);
    wire logic sel_flag = (avs_address == OFS_FLAG);
    wire logic sel_status = (avs_address == OFS_STATUS);
    wire logic sel_mask = (avs_address == OFS_MASK);
    wire logic lane0 = avs_byteenable[0];
    wire logic wr_ctrl = bus_done & avs_write & sel_ctrl & lane0;
    wire logic wr_flag = bus_done & avs_write & sel_flag & lane0;
    wire logic wr_mask = bus_done & avs_write & sel_mask & lane0;
    wire logic rd_flag = bus_done & avs_read & sel_flag;
    wire logic rd_status = bus_done & avs_read & sel_status;

    // control fields
    wire logic master_mode = ctrl[CTRL_MASTER];
    wire logic wait_insert = ctrl[CTRL_WAIT];
    wire logic ack_check_enable = ctrl[CTRL_ACK_CHECK_ENABLE];
    wire logic format_select = ctrl[CTRL_FS];
    wire logic format_select_ext = ctrl[CTRL_FSX];
    wire logic start_request = ctrl[CTRL_START];
    // both format bits set selects the synchronous serial format
    wire logic i2c_format = ~(format_select & format_select_ext);

    // flag fields
    wire logic arbitration_lost_flag = flags[FLAG_AL];
    wire logic ack_received_bit = flags[FLAG_ACK_RECEIVED_BIT];
    wire logic tx_buffer_empty_flag = flags[FLAG_TXE];

    // setting conditions
    wire logic master_i2c = master_mode & i2c_format;
    wire logic set_start = master_i2c & (state == ST_START_PEND) & ev.start_seen;
    wire logic set_wait8 = master_i2c & (state == ST_XFER) & wait_insert
                           & ev.eighth_fall;
    wire logic set_done9 = master_i2c & (state == ST_XFER) & ~wait_insert
                           & ev.ninth_rise;
    wire logic set_addr_al = i2c_format & (state == ST_LOST) & ev.first_frame
                             & ev.ninth_rise;
    wire logic set_nack = master_i2c & (state == ST_XFER) & ack_check_enable
                          & ev.ninth_rise & ev.sda_lvl;
    // our released data line read low during a data bit means another master won
    wire logic conflict = master_i2c & (state == ST_XFER) & ev.scl_rise
                          & (ev.bit_index < BIT_DATA_LAST) & sda_released & ~ev.sda_lvl;
    wire logic set_al = conflict;

    wire logic [EV_W-1:0] events = {set_al, set_nack, set_addr_al, set_done9,
                                    set_wait8, set_start};
    wire logic any_set = |events;

    // clear of the flag needs a prior read that saw it set
    wire logic flag_clear = wr_flag & clear_armed & ~avs_writedata[FLAG_IRQ];

    // master sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (master_mode && start_request) begin
                    next_state = ST_START_PEND;
                end
            end
            ST_START_PEND: begin
                if (!master_mode) begin
                    next_state = ST_IDLE;
                end else if (ev.start_seen) begin
                    next_state = ST_XFER;
                end
            end
            ST_XFER: begin
                if (conflict) begin
                    next_state = ST_LOST;
                end else if (ev.stop_seen || !master_mode) begin
                    next_state = ST_IDLE;
                end
            end
            ST_LOST: begin
                // stays out of the way until the bus frees
                if (ev.stop_seen) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // control register; start request drops once the start is on the lines
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= avs_writedata[CTRL_W-1:0];
        end else if (state == ST_START_PEND && ev.start_seen) begin
            ctrl[CTRL_START] <= 1'b0;
        end
    end

    // interrupt request flag: set wins over clear, writing 1 does nothing
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags[FLAG_IRQ] <= 1'b0;
        end else if (any_set) begin
            flags[FLAG_IRQ] <= 1'b1;
        end else if (flag_clear) begin
            flags[FLAG_IRQ] <= 1'b0;
        end
    end

    // arming: a read of the flag register showing 1, spent by the next write to it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            clear_armed <= 1'b0;
        end else if (rd_flag) begin
            clear_armed <= flags[FLAG_IRQ];
        end else if (wr_flag) begin
            clear_armed <= 1'b0;
        end
    end

    // transmit buffer empty rises with the start of the first frame
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags[FLAG_TXE] <= 1'b0;
        end else if (set_start) begin
            flags[FLAG_TXE] <= 1'b1;
        end else if (wr_flag && !avs_writedata[FLAG_TXE]) begin
            flags[FLAG_TXE] <= 1'b0;
        end
    end

    // received acknowledge bit is only set while checking is on
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags[FLAG_ACK_RECEIVED_BIT] <= 1'b0;
        end else if (set_nack) begin
            flags[FLAG_ACK_RECEIVED_BIT] <= 1'b1;
        end else if (wr_flag && !avs_writedata[FLAG_ACK_RECEIVED_BIT]) begin
            flags[FLAG_ACK_RECEIVED_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags[FLAG_AL] <= 1'b0;
        end else if (set_al) begin
            flags[FLAG_AL] <= 1'b1;
        end else if (wr_flag && !avs_writedata[FLAG_AL]) begin
            flags[FLAG_AL] <= 1'b0;
        end
    end

    // sticky event status, cleared by reading it; a new event beats the clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status <= EV_RESET;
        end else if (rd_status) begin
            status <= events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask <= EV_RESET;
        end else if (wr_mask) begin
            mask <= avs_writedata[EV_W-1:0];
        end
    end

    // one wait state: read data is captured while waitrequest is high
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    wire logic [DATA_W-1:0] flag_word = {{(DATA_W-FLAG_W){1'b0}}, flags};
    wire logic [DATA_W-1:0] read_mux = sel_ctrl ? zext_ctrl(ctrl) :
                                       sel_flag ? flag_word :
                                       sel_status ? zext_ev(status) :
                                       sel_mask ? zext_ev(mask) : '0;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= '0;
        end else if (avs_read && !bus_ack) begin
            rdata <= read_mux;
        end
    end

    assign avs_readdata = rdata;
    assign avs_waitrequest = bus_req & ~bus_ack;
    assign iface_irq_flag = flags[FLAG_IRQ];
    assign irq = |(status & mask);

    // spare status for debug is not needed; unused readbacks kept to zero
    wire logic unused_ok = ack_received_bit & tx_buffer_empty_flag
                           & arbitration_lost_flag & ev.scl_lvl & ev.in_frame;
endmodule // irq_flag_core

// ===== verif/i2c_line_model.sv
// behavioural far side of the two-wire bus: drives the clock and data lines
// lines idle high as with pull-ups; the serial clock stands still outside frames
`timescale 1ns/1ps
module i2c_line_model (
    // bus lines
    output logic scl_line,
    output logic sda_line
);
    initial begin
        scl_line = 1'b1;
        sda_line = 1'b1;
    end
    // odd offset keeps line changes away from the system clock edges
    task automatic start_cond();
        #13;
        sda_line = 1'b0;
        #100;
        scl_line = 1'b0;
        #100;
    endtask
    // 400 ns serial clock period: 200 low, 200 high
    task automatic send_bit(input logic b);
        sda_line = b;
        #100;
        scl_line = 1'b1;
        #200;
        scl_line = 1'b0;
        #100;
    endtask
    task automatic send_byte(input logic [7:0] d, input logic ack);
        for (int i = 7; i >= 0; i--) send_bit(d[i]);
        send_bit(ack);
    endtask
    task automatic stop_cond();
        sda_line = 1'b0;
        #100;
        scl_line = 1'b1;
        #100;
        sda_line = 1'b1;
        #100;
    endtask
endmodule // i2c_line_model

// ===== verif/irq_flag_chk.sv
// assertion checker for the interrupt-flag core, bound to its top ports
// assumes one clock domain on sys_clk with an asynchronous active-low reset
`timescale 1ns/1ps
module irq_flag_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // avalon-mm
    input wire logic [irqflag_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [irqflag_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [irqflag_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    // pins and flags
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_released,
    input wire logic iface_irq_flag,
    input wire logic irq
);
    import irqflag_pkg::*;
    logic [1:0] pins_q;
    logic [3:0] quiet_cnt;
    logic armed;
    wire rd_done = avs_read && !avs_waitrequest;
    wire wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire flag_wr = wr_done && avs_address == OFS_FLAG;
    wire clr_wr = flag_wr && !avs_writedata[FLAG_IRQ];
    wire pins_moved = pins_q != {scl_in, sda_in};
    // quiet_cnt: cycles since either line last moved, saturating
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_q <= 2'h3;
            quiet_cnt <= 4'h0;
        end else begin
            pins_q <= {scl_in, sda_in};
            quiet_cnt <= pins_moved ? 4'h0 : quiet_cnt + {3'h0, quiet_cnt != 4'hf};
        end
    end
    // the last flag read decides whether a zero write may clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            armed <= 1'b0;
        end else if (rd_done && avs_address == OFS_FLAG) begin
            armed <= avs_readdata[FLAG_IRQ];
        end else if (flag_wr) begin
            armed <= 1'b0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_two_step;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence s_quiet_status_read;
        rd_done && avs_address == OFS_STATUS && quiet_cnt == 4'hf;
    endsequence
    property p_reset_clear;
        $rose(reset_n) |-> !iface_irq_flag && !irq;
    endproperty
    property p_flag_hold;
        iface_irq_flag && !clr_wr |=> iface_irq_flag;
    endproperty
    property p_clear_armed;
        $fell(iface_irq_flag) |-> $past(armed) && $past(clr_wr);
    endproperty
    property p_flag_cause;
        $rose(iface_irq_flag) |-> quiet_cnt <= 4'h8;
    endproperty
    property p_two_cycle;
        $rose(avs_read || avs_write) |-> s_two_step;
    endproperty
    property p_idle_ready;
        !avs_read && !avs_write |-> !avs_waitrequest;
    endproperty
    property p_unmapped;
        rd_done && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0;
    endproperty
    property p_mask_off;
        wr_done && avs_address == OFS_MASK && avs_writedata[EV_W-1:0] == 6'h00 |=> !irq [*3];
    endproperty
    property p_status_clear;
        s_quiet_status_read |=> !irq;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("flag or irq high after reset");
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag dropped without a clearing write");
    a_clear_armed: assert property (p_clear_armed)
        else $error("flag cleared without a prior read of 1");
    a_flag_cause: assert property (p_flag_cause)
        else $error("flag rose with quiet bus lines");
    a_two_cycle: assert property (p_two_cycle)
        else $error("bus access not two cycles");
    a_idle_ready: assert property (p_idle_ready)
        else $error("waitrequest high while idle");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_mask_off: assert property (p_mask_off)
        else $error("irq high with all events masked");
    a_status_clear: assert property (p_status_clear)
        else $error("irq still high after status read");
endmodule // irq_flag_chk

// ===== verif/irq_flag_core_tb.sv
// self-checking bench for the interrupt-flag core; reads are checked from a queue
// assumes the line model owns both pins and the bench drives sda_released
`timescale 1ns/1ps
module irq_flag_core_tb;
    import irqflag_pkg::*;
    typedef struct {string nm; logic [31:0] e; logic [31:0] m;} note_t;
    localparam logic [7:0] CTL [5] = '{8'h21, 8'h23, 8'h25, 8'h39, 8'h21};
    localparam logic [5:0] STX [5] = '{6'h05, 6'h03, 6'h15, 6'h00, 6'h29};
    localparam logic [3:0] FLX [5] = '{4'h3, 4'h3, 4'h7, 4'h0, 4'hb};
    localparam logic ACK [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    note_t notes[$];
    note_t cur;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic sda_released = 1'b0;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest, iface_irq_flag, irq, scl_in, sda_in;
    logic [31:0] lfsr = 32'h0593;
    int miscompares = 0;
    int n_compared = 0;
    always #25 sys_clk = ~sys_clk;
    irq_flag_core irq_flag_core_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_in),
        .sda_in(sda_in), .sda_released(sda_released), .iface_irq_flag(iface_irq_flag),
        .irq(irq));
    i2c_line_model i2c_line_model_i (.scl_line(scl_in), .sda_line(sda_in));
    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        if (notes.size() != 0) miscompares++;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // request held until waitrequest is seen low, then released at that edge
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, input string nm, input logic [31:0] e,
                       input logic [31:0] m);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= we;
        avs_read <= !we;
        avs_writedata <= d;
        avs_byteenable <= be;
        if (!we) notes.push_back('{nm, e, m});
        // only the watchdog ends a wait that never finishes
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        r = next_rand();
        bus(1'b1, a, {r[31:8], d[7:0]}, 4'h1, "", 32'h0, 32'h0);
    endtask
    task automatic rd(input logic [3:0] a, input string nm, input logic [31:0] e,
                      input logic [31:0] m);
        bus(1'b0, a, 32'h0, 4'hf, nm, e, m);
    endtask
    always @(negedge sys_clk) begin
        if (avs_read && !avs_waitrequest) begin
            if (notes.size() == 0) begin
                check("unexpected read", 32'h1, 32'h0);
            end else begin
                cur = notes.pop_front();
                check(cur.nm, avs_readdata & cur.m, cur.e & cur.m);
            end
        end
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        conclude();
    end
    initial begin
        logic [31:0] r;
        logic [5:0] msk;
        logic [5:0] stm;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 16; a += 4) rd(a[3:0], "reset value", 32'h0, 32'hffffffff);
        rd(4'h1, "unmapped", 32'h0, 32'hffffffff);
        wr(OFS_FLAG, 32'h0f);
        rd(OFS_FLAG, "flag after write 1", 32'h0, 32'hf);
        r = next_rand();
        bus(1'b1, OFS_MASK, r, 4'h0, "", 32'h0, 32'h0);
        rd(OFS_MASK, "mask ignored write", 32'h0, 32'hffffffff);
        wr(OFS_MASK, r);
        rd(OFS_MASK, "mask readback", {26'h0, r[5:0]}, 32'hffffffff);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            // arbitration row leaves the done bit open: the lost master may skip it
            stm = (i == 4) ? 6'h39 : 6'h3f;
            msk = (i == 1) ? 6'h00 : stm;
            wr(OFS_MASK, {26'h0, msk});
            wr(OFS_CTRL, {24'h0, CTL[i]});
            sda_released <= (i == 4);
            r = next_rand();
            i2c_line_model_i.start_cond();
            i2c_line_model_i.send_byte((i == 4) ? {1'b0, r[6:0]} : r[7:0], ACK[i]);
            i2c_line_model_i.stop_cond();
            sda_released <= 1'b0;
            repeat (20) @(posedge sys_clk);
            check("irq level", {31'h0, irq}, {31'h0, |(msk & STX[i])});
            check("flag level", {31'h0, iface_irq_flag}, {31'h0, FLX[i][0]});
            wr(OFS_FLAG, 32'h0e);
            @(negedge sys_clk);
            check("flag kept", {31'h0, iface_irq_flag}, {31'h0, FLX[i][0]});
            rd(OFS_STATUS, "status", {26'h0, STX[i]}, {26'h0, stm});
            rd(OFS_FLAG, "flag", {28'h0, FLX[i]}, 32'hf);
            wr(OFS_FLAG, 32'h0);
            rd(OFS_FLAG, "flag cleared", 32'h0, 32'hf);
            @(negedge sys_clk);
            check("irq after status read", {31'h0, irq}, 32'h0);
            check("flag after clear", {31'h0, iface_irq_flag}, 32'h0);
            $display("test frame %0d done", i);
        end
        conclude();
    end
endmodule // irq_flag_core_tb
bind irq_flag_core irq_flag_chk irq_flag_chk_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_in),
    .sda_in(sda_in), .sda_released(sda_released), .iface_irq_flag(iface_irq_flag),
    .irq(irq));
